// ### verilog/dpsm_defs.svh
`ifndef DPSM_DEFS_SVH
`define DPSM_DEFS_SVH

// object indices
`define DPSM_IDX_CMD 16'h6040
`define DPSM_IDX_STATE 16'h6041
`define DPSM_IDX_MODE_REQ 16'h6060
`define DPSM_IDX_MODE_ACT 16'h6061
`define DPSM_IDX_SUBMODE 16'h3202
`define DPSM_IDX_QS_OPT 16'h605a
`define DPSM_IDX_HALT_OPT 16'h605d

// command word bit positions
`define DPSM_CMD_SWON 0
`define DPSM_CMD_VOLT 1
`define DPSM_CMD_QSTOP 2
`define DPSM_CMD_ENOP 3
`define DPSM_CMD_FRST 7
`define DPSM_CMD_HALT 8

// submode bit positions
`define DPSM_SUB_CLOSED 0
`define DPSM_SUB_SLOW 7

// state word encodings
`define DPSM_SW_NOT_READY 16'h0000
`define DPSM_SW_SO_DIS 16'h0040
`define DPSM_SW_READY 16'h0021
`define DPSM_SW_SWON 16'h0023
`define DPSM_SW_OPEN 16'h0027
`define DPSM_SW_QSTOP 16'h0007
`define DPSM_SW_FREACT 16'h000f
`define DPSM_SW_FAULT 16'h0008

// stop option codes
`define DPSM_QS_IMMED 16'h0000
`define DPSM_QS_MODE 16'h0001
`define DPSM_QS_QUICK 16'h0002
`define DPSM_QS_MODE_HOLD 16'h0005
`define DPSM_QS_QUICK_HOLD 16'h0006
`define DPSM_HALT_MODE 16'h0001
`define DPSM_HALT_QUICK 16'h0002

// reset values
`define DPSM_RST_QS_OPT 16'h0002
`define DPSM_RST_HALT_OPT 16'h0001
`define DPSM_RST_MODE 8'h00
`define DPSM_RST_SUBMODE 16'h0000

// changeover hysteresis in percent
`define DPSM_HYST_PCT 10

`endif

// ### verilog/dpsm_pkg.sv
package dpsm_pkg;

  typedef enum logic [2:0] {
    DPSM_NOT_READY = 3'b000,
    DPSM_SO_DIS = 3'b001,
    DPSM_READY = 3'b010,
    DPSM_SWON = 3'b011,
    DPSM_OPEN = 3'b100,
    DPSM_QSTOP = 3'b101,
    DPSM_FREACT = 3'b110,
    DPSM_FAULT = 3'b111
  } dpsm_state_t;

  typedef enum logic [1:0] {
    DPSM_RAMP_NONE = 2'b00,
    DPSM_RAMP_MODE = 2'b01,
    DPSM_RAMP_QUICK = 2'b10
  } dpsm_ramp_t;

endpackage

// ### verilog/dpsm_speed_if.sv
`timescale 1ns/1ps
interface dpsm_speed_if #(
  parameter int W = 24
);
  logic signed [W-1:0] speed;
  logic [W-1:0] speedAbs;
  logic valid;

  modport src (output speed, output speedAbs, output valid);
  modport snk (input speed, input speedAbs, input valid);
endinterface

// ### verilog/dpsm_speed_est.sv
`timescale 1ns/1ps
module dpsm_speed_est #(
  parameter int POS_W = 32,
  parameter int W = 24,
  parameter int LPF_SHIFT = 3
) (
  input wire logic core_clk, // drive clock
  input wire logic nrst, // sync reset, active low
  input wire logic ctrlTick, // one pulse per control cycle
  input wire logic [POS_W-1:0] encPos, // encoder position count
  dpsm_speed_if.src spd // filtered speed out
);
  logic [POS_W-1:0] lastPos_r;
  logic signed [W-1:0] raw;
  logic signed [W-1:0] filt_nxt;

  // cycle time is fixed, so increments per cycle already is the speed
  assign raw = W'(encPos - lastPos_r);
  assign filt_nxt = spd.speed + ((raw - spd.speed) >>> LPF_SHIFT);

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      lastPos_r <= '0;
      spd.speed <= '0;
      spd.speedAbs <= '0;
      spd.valid <= 1'b0;
    end else begin
      spd.valid <= ctrlTick;
      if (ctrlTick) begin
        lastPos_r <= encPos;
        spd.speed <= filt_nxt;
        spd.speedAbs <= filt_nxt[W-1] ? W'(-filt_nxt) : W'(filt_nxt);
      end
    end
  end
endmodule

// ### verilog/dpsm_slow_speed.sv
`timescale 1ns/1ps
`include "dpsm_defs.svh"
module dpsm_slow_speed #(
  parameter int W = 24,
  parameter logic [23:0] CHANGE_SPEED = 24'h000010,
  parameter logic [31:0] FOLLOW_LIMIT = 32'h00000100
) (
  input wire logic core_clk, // drive clock
  input wire logic nrst, // sync reset, active low
  input wire logic closedEn, // closed loop selected
  input wire logic slowEn, // slow speed selected
  input wire logic [31:0] followErrAbs, // magnitude of following error
  dpsm_speed_if.snk spd, // filtered speed in
  output logic slowActive_r, // constant phase current regime
  output logic vectorOn_r // field vector control engaged
);
  localparam logic [W-1:0] HI = W'(CHANGE_SPEED);
  localparam logic [W-1:0] LO = W'(CHANGE_SPEED - (CHANGE_SPEED * `DPSM_HYST_PCT) / 100);
  logic followBad;

  assign followBad = followErrAbs > FOLLOW_LIMIT;

  // follows speed only on fresh samples so noise between samples is ignored; deselecting closed or slow clears it at once
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      slowActive_r <= 1'b0;
    end else if (!(closedEn && slowEn)) begin
      slowActive_r <= 1'b0;
    end else if (spd.valid) begin
      if (spd.speedAbs == '0) begin
        slowActive_r <= 1'b0;
      end else if (slowActive_r && spd.speedAbs >= HI) begin
        slowActive_r <= 1'b0;
      end else if (!slowActive_r && spd.speedAbs < LO) begin
        slowActive_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      vectorOn_r <= 1'b0;
    end else if (!closedEn) begin
      vectorOn_r <= 1'b0;
    end else if (slowActive_r) begin
      vectorOn_r <= followBad;
    end else begin
      vectorOn_r <= 1'b1;
    end
  end
endmodule

// ### verilog/dpsm_top.sv
// Notes on behaviour
// - Host-commanded power-state changes come only from writes to the command word object.
// - State word object shows the power state encoding, registered one clock behind the state.
// - Shutdown 0x110 gives transitions 2,6,8; switch on 00111 gives 3.
// - Bit7,bit1 clear is disable voltage; bit2 clear, bit1 set is quick stop.
// - Bits 3..0 set enable operation; bit3 clear, 2..0 set disable operation.
// - Quick stop to operation enabled only on rising quick-stop bit edge.
// - Fault cleared only on rising edge of fault-reset bit; level does nothing.
// - Not ready, switch-on disabled, fault reaction and fault status encodings.
// - Ready, switched on, operation enabled and quick stop status encodings.
// - After reset, self-test passes then switch-on disabled awaits commands.
// - Unrecoverable error locks the block in not ready, ignoring commands.
// - Operating mode request accepted at any time in any state.
// - Active operating mode shown in its own read-back object.
// - Closed loop runs only with submode bit 0; auto setup sets it.
// - Slow speed needs closed loop enabled plus submode bit 7.
// - Slow/closed changeover at a fixed speed with 10 percent hysteresis.
// - At standstill with slow speed enabled, run closed loop.
// - Slow speed drives constant current, watches following error, may engage vector.
// - Speed is position change per control cycle, low-pass filtered.
// - Quick stop option 0,1,2 end in switch-on disabled; 5,6 hold energized.
// - Halt bit applies halt option: 1 mode ramp, 2 quick-stop ramp.
`timescale 1ns/1ps
`include "dpsm_defs.svh"
module dpsm_top #(
  parameter int POS_W = 32,
  parameter int SPD_W = 24,
  parameter int LPF_SHIFT = 3,
  parameter logic [23:0] CHANGE_SPEED = 24'h000010,
  parameter logic [31:0] FOLLOW_LIMIT = 32'h00000100
) (
  input wire logic core_clk, // drive clock, 40 MHz
  input wire logic nrst, // sync reset, active low
  input wire logic objWrEn, // object write strobe
  input wire logic [15:0] objIndex, // object index of the write
  input wire logic [15:0] objWrData, // object write value
  input wire logic selfTestDone, // self-test finished pulse
  input wire logic selfTestPass, // self-test result, valid with done
  input wire logic fatalErr, // unrecoverable error pulse
  input wire logic faultIn, // recoverable fault level
  input wire logic motionStopped, // braking finished, motor at rest
  input wire logic autoSetupDone, // auto setup completed pulse
  input wire logic ctrlTick, // control cycle pulse
  input wire logic [POS_W-1:0] encPos, // encoder position
  input wire logic [31:0] followErrAbs, // following error magnitude
  output logic [15:0] stateWord, // state word object
  output logic [7:0] modeActive, // active operating mode object
  output logic [15:0] submodeWord, // submode selection object
  output logic driveEnergized, // power stage on
  output logic [1:0] rampSel, // braking ramp in use
  output logic haltActive, // halt braking in progress
  output logic closedLoopOn, // closed loop selected
  output logic slowSpeedOn, // slow speed regime running
  output logic vectorCtrlOn, // field vector control engaged
  output logic signed [SPD_W-1:0] speedEst // filtered speed
);
  dpsm_pkg::dpsm_state_t state_r;
  dpsm_pkg::dpsm_ramp_t ramp_r;
  logic [15:0] prevCmd_r;
  logic [15:0] qsOpt_r;
  logic [15:0] qsLatched_r;
  logic [15:0] haltOpt_r;
  logic [7:0] modeReq_r;
  logic [7:0] modeAct_r;
  logic [15:0] submode_r;
  logic [15:0] stateWord_r;
  logic fatalLock_r;
  logic energized_r;
  logic halt_r;
  logic slowActive;
  logic vectorOn;

  logic cmdWr;
  logic [15:0] c;
  logic doShutdown;
  logic doSwitchOn;
  logic doDisVolt;
  logic doQuickStop;
  logic doEnOp;
  logic doDisOp;
  logic doResume;
  logic doFaultRst;
  logic qsHold;
  logic qsLeave;

  dpsm_speed_if #(.W(SPD_W)) spdBus();

  assign cmdWr = objWrEn && (objIndex == `DPSM_IDX_CMD);
  assign c = objWrData;

  // decode on the written value; unlisted bits do not matter
  assign doShutdown = cmdWr && !c[`DPSM_CMD_FRST] && c[`DPSM_CMD_QSTOP]
    && c[`DPSM_CMD_VOLT] && !c[`DPSM_CMD_SWON];
  assign doSwitchOn = cmdWr && !c[`DPSM_CMD_FRST] && !c[`DPSM_CMD_ENOP]
    && c[`DPSM_CMD_QSTOP] && c[`DPSM_CMD_VOLT] && c[`DPSM_CMD_SWON];
  assign doDisOp = doSwitchOn;
  assign doDisVolt = cmdWr && !c[`DPSM_CMD_FRST] && !c[`DPSM_CMD_VOLT];
  assign doQuickStop = cmdWr && !c[`DPSM_CMD_FRST] && !c[`DPSM_CMD_QSTOP]
    && c[`DPSM_CMD_VOLT];
  assign doEnOp = cmdWr && !c[`DPSM_CMD_FRST] && c[`DPSM_CMD_ENOP]
    && c[`DPSM_CMD_QSTOP] && c[`DPSM_CMD_VOLT] && c[`DPSM_CMD_SWON];
  // edges are judged between consecutive command writes, not levels
  assign doResume = cmdWr && !c[`DPSM_CMD_FRST] && c[`DPSM_CMD_ENOP]
    && c[`DPSM_CMD_VOLT] && c[`DPSM_CMD_SWON]
    && c[`DPSM_CMD_QSTOP] && !prevCmd_r[`DPSM_CMD_QSTOP];
  assign doFaultRst = cmdWr && c[`DPSM_CMD_FRST]
    && !prevCmd_r[`DPSM_CMD_FRST];

  assign qsHold = (qsLatched_r == `DPSM_QS_MODE_HOLD)
    || (qsLatched_r == `DPSM_QS_QUICK_HOLD);
  assign qsLeave = !qsHold && ((qsLatched_r == `DPSM_QS_IMMED) || motionStopped);

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      prevCmd_r <= 16'h0000;
    end else if (cmdWr) begin
      prevCmd_r <= objWrData;
    end
  end

  // a failed self-test counts as unrecoverable as well
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      fatalLock_r <= 1'b0;
    end else if (fatalErr || (selfTestDone && !selfTestPass
        && state_r == dpsm_pkg::DPSM_NOT_READY)) begin
      fatalLock_r <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state_r <= dpsm_pkg::DPSM_NOT_READY;
    end else if (fatalLock_r || fatalErr) begin
      state_r <= dpsm_pkg::DPSM_NOT_READY;
    end else if (faultIn && state_r != dpsm_pkg::DPSM_NOT_READY
        && state_r != dpsm_pkg::DPSM_FREACT && state_r != dpsm_pkg::DPSM_FAULT) begin
      state_r <= dpsm_pkg::DPSM_FREACT;
    end else begin
      // anything not matched below leaves the state alone
      unique case (state_r)
        dpsm_pkg::DPSM_NOT_READY: begin
          if (selfTestDone && selfTestPass) begin
            state_r <= dpsm_pkg::DPSM_SO_DIS;
          end
        end
        dpsm_pkg::DPSM_SO_DIS: begin
          if (doShutdown) begin
            state_r <= dpsm_pkg::DPSM_READY;
          end
        end
        dpsm_pkg::DPSM_READY: begin
          if (doSwitchOn) begin
            state_r <= dpsm_pkg::DPSM_SWON;
          end else if (doDisVolt) begin
            state_r <= dpsm_pkg::DPSM_SO_DIS;
          end
        end
        dpsm_pkg::DPSM_SWON: begin
          if (doEnOp) begin
            state_r <= dpsm_pkg::DPSM_OPEN;
          end else if (doShutdown) begin
            state_r <= dpsm_pkg::DPSM_READY;
          end else if (doDisVolt) begin
            state_r <= dpsm_pkg::DPSM_SO_DIS;
          end
        end
        dpsm_pkg::DPSM_OPEN: begin
          if (doDisOp) begin
            state_r <= dpsm_pkg::DPSM_SWON;
          end else if (doShutdown) begin
            state_r <= dpsm_pkg::DPSM_READY;
          end else if (doDisVolt) begin
            state_r <= dpsm_pkg::DPSM_SO_DIS;
          end else if (doQuickStop) begin
            state_r <= dpsm_pkg::DPSM_QSTOP;
          end
        end
        dpsm_pkg::DPSM_QSTOP: begin
          if (doDisVolt) begin
            state_r <= dpsm_pkg::DPSM_SO_DIS;
          end else if (qsHold && doResume) begin
            state_r <= dpsm_pkg::DPSM_OPEN;
          end else if (qsLeave) begin
            state_r <= dpsm_pkg::DPSM_SO_DIS;
          end
        end
        dpsm_pkg::DPSM_FREACT: begin
          if (motionStopped) begin
            state_r <= dpsm_pkg::DPSM_FAULT;
          end
        end
        dpsm_pkg::DPSM_FAULT: begin
          if (doFaultRst && !faultIn) begin
            state_r <= dpsm_pkg::DPSM_SO_DIS;
          end
        end
      endcase
    end
  end

  // the option in force is frozen on entry so a rewrite mid-stop cannot
  // turn a holding stop into a releasing one
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      qsLatched_r <= `DPSM_RST_QS_OPT;
    end else if (state_r == dpsm_pkg::DPSM_OPEN && doQuickStop) begin
      qsLatched_r <= qsOpt_r;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      qsOpt_r <= `DPSM_RST_QS_OPT;
      haltOpt_r <= `DPSM_RST_HALT_OPT;
    end else if (objWrEn) begin
      if (objIndex == `DPSM_IDX_QS_OPT) begin
        qsOpt_r <= objWrData;
      end
      if (objIndex == `DPSM_IDX_HALT_OPT) begin
        haltOpt_r <= objWrData;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      modeReq_r <= `DPSM_RST_MODE;
      modeAct_r <= `DPSM_RST_MODE;
    end else begin
      if (objWrEn && objIndex == `DPSM_IDX_MODE_REQ) begin
        modeReq_r <= objWrData[7:0];
      end
      modeAct_r <= modeReq_r;
    end
  end

  // a host write in the same cycle as auto setup completion is kept, with the closed loop bit forced set
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      submode_r <= `DPSM_RST_SUBMODE;
    end else if (objWrEn && objIndex == `DPSM_IDX_SUBMODE) begin
      submode_r <= objWrData | (16'(autoSetupDone) << `DPSM_SUB_CLOSED);
    end else if (autoSetupDone) begin
      submode_r[`DPSM_SUB_CLOSED] <= 1'b1;
    end
  end

  // halt follows the last written command; reserved options brake nothing
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      halt_r <= 1'b0;
    end else begin
      halt_r <= state_r == dpsm_pkg::DPSM_OPEN && prevCmd_r[`DPSM_CMD_HALT]
        && (haltOpt_r == `DPSM_HALT_MODE || haltOpt_r == `DPSM_HALT_QUICK);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ramp_r <= dpsm_pkg::DPSM_RAMP_NONE;
    end else if (state_r == dpsm_pkg::DPSM_QSTOP) begin
      if (qsLatched_r == `DPSM_QS_MODE || qsLatched_r == `DPSM_QS_MODE_HOLD) begin
        ramp_r <= dpsm_pkg::DPSM_RAMP_MODE;
      end else if (qsLatched_r == `DPSM_QS_IMMED) begin
        ramp_r <= dpsm_pkg::DPSM_RAMP_NONE;
      end else begin
        ramp_r <= dpsm_pkg::DPSM_RAMP_QUICK;
      end
    end else if (state_r == dpsm_pkg::DPSM_OPEN && prevCmd_r[`DPSM_CMD_HALT]) begin
      if (haltOpt_r == `DPSM_HALT_MODE) begin
        ramp_r <= dpsm_pkg::DPSM_RAMP_MODE;
      end else if (haltOpt_r == `DPSM_HALT_QUICK) begin
        ramp_r <= dpsm_pkg::DPSM_RAMP_QUICK;
      end else begin
        ramp_r <= dpsm_pkg::DPSM_RAMP_NONE;
      end
    end else begin
      ramp_r <= dpsm_pkg::DPSM_RAMP_NONE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      energized_r <= 1'b0;
    end else begin
      energized_r <= state_r == dpsm_pkg::DPSM_OPEN
        || (state_r == dpsm_pkg::DPSM_QSTOP && (qsHold || !qsLeave))
        || state_r == dpsm_pkg::DPSM_FREACT;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      stateWord_r <= `DPSM_SW_NOT_READY;
    end else begin
      unique case (state_r)
        dpsm_pkg::DPSM_NOT_READY: stateWord_r <= `DPSM_SW_NOT_READY;
        dpsm_pkg::DPSM_SO_DIS: stateWord_r <= `DPSM_SW_SO_DIS;
        dpsm_pkg::DPSM_READY: stateWord_r <= `DPSM_SW_READY;
        dpsm_pkg::DPSM_SWON: stateWord_r <= `DPSM_SW_SWON;
        dpsm_pkg::DPSM_OPEN: stateWord_r <= `DPSM_SW_OPEN;
        dpsm_pkg::DPSM_QSTOP: stateWord_r <= `DPSM_SW_QSTOP;
        dpsm_pkg::DPSM_FREACT: stateWord_r <= `DPSM_SW_FREACT;
        dpsm_pkg::DPSM_FAULT: stateWord_r <= `DPSM_SW_FAULT;
      endcase
    end
  end

  dpsm_speed_est #(
    .POS_W(POS_W),
    .W(SPD_W),
    .LPF_SHIFT(LPF_SHIFT)
  ) u_est (
    .core_clk(core_clk),
    .nrst(nrst),
    .ctrlTick(ctrlTick),
    .encPos(encPos),
    .spd(spdBus.src)
  );

  // slow bit only counts once closed loop is on, whatever order it was set
  dpsm_slow_speed #(
    .W(SPD_W),
    .CHANGE_SPEED(CHANGE_SPEED),
    .FOLLOW_LIMIT(FOLLOW_LIMIT)
  ) u_slow (
    .core_clk(core_clk),
    .nrst(nrst),
    .closedEn(submode_r[`DPSM_SUB_CLOSED]),
    .slowEn(submode_r[`DPSM_SUB_SLOW]),
    .followErrAbs(followErrAbs),
    .spd(spdBus.snk),
    .slowActive_r(slowActive),
    .vectorOn_r(vectorOn)
  );

  assign stateWord = stateWord_r;
  assign modeActive = modeAct_r;
  assign submodeWord = submode_r;
  assign driveEnergized = energized_r;
  assign rampSel = ramp_r;
  assign haltActive = halt_r;
  assign closedLoopOn = submode_r[`DPSM_SUB_CLOSED];
  assign slowSpeedOn = slowActive;
  assign vectorCtrlOn = vectorOn;
  assign speedEst = spdBus.speed;
endmodule

// ### dv/dpsm_host_model.sv
`timescale 1ns/1ps
module dpsm_host_model (
  input wire logic core_clk, // drive clock
  output logic objWrEn, // write strobe
  output logic [15:0] objIndex, // object index
  output logic [15:0] objWrData // write value
);
  initial begin
    objWrEn = 1'b0;
    objIndex = 16'h0000;
    objWrData = 16'h0000;
  end
  // one single-cycle write per call, launched on the falling edge
  task automatic put(input logic [15:0] idx, input logic [15:0] val);
    @(negedge core_clk);
    objWrEn <= 1'b1;
    objIndex <= idx;
    objWrData <= val;
    @(negedge core_clk);
    objWrEn <= 1'b0;
    // idle bus must not look like a stale request
    objIndex <= ~idx;
    objWrData <= ~val;
  endtask
endmodule

// ### dv/dpsm_top_properties.sv
`timescale 1ns/1ps
module dpsm_top_properties (
  input wire logic core_clk, // drive clock
  input wire logic nrst, // sync reset, active low
  input wire logic objWrEn, // write strobe
  input wire logic [15:0] objIndex, // write index
  input wire logic [15:0] objWrData, // write value
  input wire logic faultIn, // fault level
  input wire logic fatalErr, // lock request
  input wire logic autoSetupDone, // setup finished
  input wire logic [15:0] stateWord, // state word
  input wire logic [7:0] modeActive, // active mode
  input wire logic closedLoopOn // closed loop flag
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic [15:0] lastCmd_r;
  logic calm_r;
  logic cmdWr;
  logic modeWr;
  logic calm;
  logic [7:0] modeVal;
  assign cmdWr = objWrEn && objIndex == 16'h6040;
  assign modeWr = objWrEn && objIndex == 16'h6060;
  assign modeVal = objWrData[7:0];
  // quiet cycle before: state word then shows the present state
  assign calm = calm_r && !faultIn && !fatalErr;
  always_ff @(posedge core_clk) begin
    calm_r <= !objWrEn && !faultIn && !fatalErr;
  end
  always_ff @(posedge core_clk) begin
    if (!nrst)
      lastCmd_r <= 16'h0000;
    else if (cmdWr)
      lastCmd_r <= objWrData;
  end
  reset_clears_a:
    assert property (disable iff (1'b0) !nrst |=> stateWord == 16'h0000)
    else $error("state word not cleared by reset");
  state_code_a:
    assert property (stateWord inside {16'h0000, 16'h0040, 16'h0021, 16'h0023,
      16'h0027, 16'h0007, 16'h000f, 16'h0008})
    else $error("state word holds an undefined code");
  shutdown_ready_a:
    assert property (cmdWr && calm && stateWord == 16'h0040 && !objWrData[7]
      && objWrData[2:0] == 3'b110 |-> ##2 stateWord == 16'h0021)
    else $error("shutdown did not reach ready");
  enable_op_a:
    assert property (cmdWr && calm && stateWord == 16'h0023 && !objWrData[7]
      && objWrData[3:0] == 4'hf |-> ##2 stateWord == 16'h0027)
    else $error("enable operation not taken");
  quick_stop_a:
    assert property (cmdWr && calm && stateWord == 16'h0027 && !objWrData[7]
      && objWrData[2:1] == 2'b01 |-> ##2 stateWord == 16'h0007)
    else $error("quick stop not entered");
  resume_edge_a:
    assert property (cmdWr && calm && stateWord == 16'h0007 && lastCmd_r[2]
      |-> ##2 stateWord != 16'h0027)
    else $error("resume taken without rising edge");
  fault_edge_a:
    assert property (cmdWr && calm && stateWord == 16'h0008 && objWrData[7]
      && lastCmd_r[7] |-> ##2 stateWord == 16'h0008)
    else $error("fault cleared by a held level");
  fatal_lock_a:
    assert property (fatalErr |-> ##2 (stateWord == 16'h0000) [*8])
    else $error("fatal lock left not ready");
  mode_readback_a:
    assert property ($past(modeWr, 2) |-> modeActive == $past(modeVal, 2))
    else $error("active mode does not follow request");
  setup_closed_a:
    assert property (autoSetupDone |-> ##[1:3] closedLoopOn)
    else $error("auto setup did not select closed loop");
  cover property (cmdWr && stateWord == 16'h0007 && objWrData[3:0] == 4'hf && !lastCmd_r[2]);
  cover property (stateWord == 16'h0008 ##1 stateWord == 16'h0040);
  cover property (fatalErr);
endmodule
bind dpsm_top dpsm_top_properties i_props (.core_clk, .nrst, .objWrEn, .objIndex,
  .objWrData, .faultIn, .fatalErr, .autoSetupDone, .stateWord, .modeActive, .closedLoopOn);

// ### dv/tb_drive_power_state_machine.sv
`timescale 1ns/1ps
module tb_drive_power_state_machine;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic objWrEn;
  logic [15:0] objIndex, objWrData, stateWord, submodeWord, exp, prevCmd, d;
  logic selfTestDone = 1'b0, selfTestPass = 1'b0, fatalErr = 1'b0, faultIn = 1'b0;
  logic motionStopped = 1'b0, autoSetupDone = 1'b0, ctrlTick = 1'b0;
  logic [31:0] encPos = 32'h0, followErrAbs = 32'h0;
  logic [7:0] modeActive, m;
  logic [1:0] rampSel;
  logic driveEnergized, haltActive, closedLoopOn, slowSpeedOn, vectorCtrlOn;
  logic signed [23:0] speedEst;
  logic [15:0] qsOpt [5] = '{16'h0000, 16'h0001, 16'h0002, 16'h0005, 16'h0006};
  int fail_count = 0;
  int n_compared = 0;
  always #12.5 core_clk = ~core_clk;
  dpsm_host_model i_host (.core_clk, .objWrEn, .objIndex, .objWrData);
  dpsm_top i_dut (.core_clk, .nrst, .objWrEn, .objIndex, .objWrData, .selfTestDone,
    .selfTestPass, .fatalErr, .faultIn, .motionStopped, .autoSetupDone, .ctrlTick,
    .encPos, .followErrAbs, .stateWord, .modeActive, .submodeWord, .driveEnergized,
    .rampSel, .haltActive, .closedLoopOn, .slowSpeedOn, .vectorCtrlOn, .speedEst);
  function automatic logic [15:0] nxt(logic [15:0] s, logic [15:0] c, logic [15:0] p);
    nxt = s;
    if (c[7])
      return s;
    if (!c[1] && s inside {16'h0021, 16'h0023, 16'h0027, 16'h0007})
      return 16'h0040;
    case (s)
      16'h0040: if (c[2:0] == 3'b110) nxt = 16'h0021;
      16'h0021: if (c[3:0] == 4'h7) nxt = 16'h0023;
      16'h0023: if (c[2:0] == 3'b110) nxt = 16'h0021;
        else if (c[3:0] == 4'hf) nxt = 16'h0027;
      16'h0027: if (c[2:1] == 2'b01) nxt = 16'h0007;
        else if (c[2:0] == 3'b110) nxt = 16'h0021;
        else if (c[3:0] == 4'h7) nxt = 16'h0023;
      16'h0007: if (c[3:0] == 4'hf && !p[2]) nxt = 16'h0027;
      default: ;
    endcase
  endfunction
  function automatic logic [15:0] ramp(logic [15:0] o);
    return o == 16'h0 ? 16'h0 : (o == 16'h1 || o == 16'h5) ? 16'h1 : 16'h2;
  endfunction
  task automatic chkw(input logic [15:0] got, input logic [15:0] want, input string what);
    n_compared++;
    if (got !== want) begin
      fail_count++;
      $display("CHECK FAILED %0t %s got %h want %h", $time, what, got, want);
    end
  endtask
  task automatic chkb(input logic got, input logic want, input string what);
    n_compared++;
    if (got !== want) begin
      fail_count++;
      $display("CHECK FAILED %0t %s got %b", $time, what, got);
    end
  endtask
  task automatic cmdx(input logic [15:0] c, input logic [15:0] e);
    i_host.put(16'h6040, c);
    prevCmd = c;
    exp = e;
    @(negedge core_clk);
    chkw(stateWord, exp, "state");
  endtask
  task automatic cmd(input logic [15:0] c);
    cmdx(c, nxt(exp, c, prevCmd));
  endtask
  task automatic wait_chk(input int n, input logic [15:0] e, input string what);
    repeat (n) @(negedge core_clk);
    chkw(stateWord, e, what);
  endtask
  task automatic ticks(input int n, input logic [31:0] inc);
    repeat (n) begin
      @(negedge core_clk);
      encPos = encPos + inc;
      ctrlTick = 1'b1;
      @(negedge core_clk);
      ctrlTick = 1'b0;
      repeat (2) @(negedge core_clk);
    end
  endtask
  task automatic results();
    if (fail_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #500000;
    fail_count++;
    results();
  end
  initial begin
    prevCmd = 16'h0000;
    d = 16'($urandom(32'h09d6));
    repeat (5) @(negedge core_clk);
    nrst = 1'b1;
    chkw(stateWord, 16'h0000, "not ready");
    chkb(closedLoopOn, 1'b0, "closed at reset");
    selfTestDone = 1'b1;
    selfTestPass = 1'b1;
    @(negedge core_clk);
    selfTestDone = 1'b0;
    wait_chk(1, 16'h0040, "self-test");
    exp = 16'h0040;
    cmd(16'h000f);
    cmd(16'h0007);
    foreach (qsOpt[i]) begin
      i_host.put(16'h605a, qsOpt[i]);
      cmd(16'h0006);
      cmd(16'h0007);
      cmd(16'h000f);
      cmd(16'h0002);
      repeat (3) @(negedge core_clk);
      chkw({14'h0, rampSel}, ramp(qsOpt[i]), "ramp");
      if (qsOpt[i] >= 16'h5) begin
        chkb(driveEnergized, 1'b1, "energized");
        cmd(16'h0006);
        cmd(16'h000f);
        cmd(16'h000b);
        cmd(16'h000f);
        cmd(16'h0000);
      end else begin
        chkw(stateWord, qsOpt[i] == 16'h0 ? 16'h0040 : 16'h0007, "braking");
        motionStopped = 1'b1;
        wait_chk(2, 16'h0040, "stopped");
        motionStopped = 1'b0;
        exp = 16'h0040;
      end
    end
    for (int k = 0; k < 300; k++) begin
      d = {8'h00, ($urandom % 6 == 0), 3'b000, 4'($urandom)};
      cmd(d);
      if (k % 25 == 0) begin
        m = 8'($urandom);
        i_host.put(16'h6060, {8'h00, m});
        @(negedge core_clk);
        chkw({8'h00, modeActive}, {8'h00, m}, "mode");
      end
    end
    cmd(16'h0000);
    faultIn = 1'b1;
    wait_chk(2, 16'h000f, "reaction");
    motionStopped = 1'b1;
    wait_chk(2, 16'h0008, "fault");
    motionStopped = 1'b0;
    cmdx(16'h0080, 16'h0008);
    faultIn = 1'b0;
    cmdx(16'h0080, 16'h0008);
    cmdx(16'h0000, 16'h0008);
    cmdx(16'h0080, 16'h0040);
    cmd(16'h0006);
    cmd(16'h0007);
    cmd(16'h000f);
    cmd(16'h010f);
    chkb(haltActive, 1'b1, "halt");
    chkw({14'h0, rampSel}, 16'h0001, "halt ramp");
    i_host.put(16'h605d, 16'h0003);
    @(negedge core_clk);
    chkb(haltActive, 1'b0, "halt reserved");
    chkw({14'h0, rampSel}, 16'h0000, "halt none");
    cmd(16'h0000);
    autoSetupDone = 1'b1;
    @(negedge core_clk);
    autoSetupDone = 1'b0;
    repeat (3) @(negedge core_clk);
    chkb(closedLoopOn, 1'b1, "auto setup");
    i_host.put(16'h3202, 16'h0001);
    i_host.put(16'h3202, 16'h0081);
    @(negedge core_clk);
    chkw(submodeWord, 16'h0081, "submode");
    ticks(40, 32'd12);
    chkb(slowSpeedOn, 1'b1, "slow");
    chkb(vectorCtrlOn, 1'b0, "vector off");
    chkb(speedEst > 0 && speedEst <= 12, 1'b1, "speed");
    followErrAbs = 32'h0000_0200;
    ticks(2, 32'd12);
    chkb(vectorCtrlOn, 1'b1, "vector");
    followErrAbs = 32'h0;
    ticks(40, 32'd40);
    chkb(slowSpeedOn, 1'b0, "fast");
    ticks(60, 32'd0);
    chkb(slowSpeedOn, 1'b0, "standstill");
    chkw(speedEst[15:0], 16'h0000, "speed rest");
    fatalErr = 1'b1;
    @(negedge core_clk);
    fatalErr = 1'b0;
    wait_chk(1, 16'h0000, "fatal");
    cmdx(16'h0006, 16'h0000);
    results();
  end
endmodule
